// ### hw/ecpg_regs.svh
`ifndef ECPG_REGS_SVH
`define ECPG_REGS_SVH

// register byte offsets on the avalon slave
`define ECPG_OFS_CTRL    6'h00
`define ECPG_OFS_CMD     6'h04
`define ECPG_OFS_RELOAD  6'h08
`define ECPG_OFS_DELAY   6'h0C
`define ECPG_OFS_HIGH    6'h10
`define ECPG_OFS_LOW     6'h14
`define ECPG_OFS_COUNT   6'h18
`define ECPG_OFS_SAVE    6'h1C
`define ECPG_OFS_STATUS  6'h20

// command bits
`define ECPG_CMD_ARM     0
`define ECPG_CMD_DISARM  1

// width of the used part of the control register
`define ECPG_CTRL_W      11

// reset values
`define ECPG_CTRL_RST    11'h000
`define ECPG_WORD_RST    32'h00000000
`define ECPG_WIDTH_RST   32'h00000001
`define ECPG_ONE         32'h00000001

// synchroniser bit positions
`define ECPG_PIN_N       6
`define ECPG_PIN_SRC     0
`define ECPG_PIN_GATE    1
`define ECPG_PIN_AUX     2
`define ECPG_PIN_A       3
`define ECPG_PIN_B       4
`define ECPG_PIN_Z       5

`endif

// ### hw/ecpg_pkg.sv
package ecpg_pkg;

   typedef enum logic [2:0] {
      ECPG_ENC_QUAD   = 3'b000,
      ECPG_ENC_TWO    = 3'b001,
      ECPG_SEP_SINGLE = 3'b010,
      ECPG_SEP_BUF    = 3'b011,
      ECPG_PUL_SINGLE = 3'b100,
      ECPG_PUL_TRIG   = 3'b101,
      ECPG_PUL_RETRIG = 3'b110,
      ECPG_PUL_TRAIN  = 3'b111
   } ecpg_mode_t;

   typedef enum logic [2:0] {
      ECPG_ST_IDLE  = 3'b000,
      ECPG_ST_WAIT  = 3'b001,
      ECPG_ST_RUN   = 3'b010,
      ECPG_ST_DELAY = 3'b011,
      ECPG_ST_HIGH  = 3'b100,
      ECPG_ST_LOW   = 3'b101,
      ECPG_ST_DONE  = 3'b110
   } ecpg_state_t;

   // control register layout, msb first
   typedef struct packed {
      logic       pause_low;
      logic       pause_en;
      logic       trig_en;
      logic [1:0] phase;
      logic       aux_fall;
      logic       gate_fall;
      logic       src_fall;
      ecpg_mode_t mode;
   } ecpg_cfg_t;

   // saved-count stream towards the dma engine
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } ecpg_stream_t;

endpackage

// ### hw/ecpg_counter.sv
`timescale 1ns/1ps
`include "ecpg_regs.svh"

module ecpg_counter (
   input  wire logic                 MCLK_I,
   input  wire logic                 NRST_I,
   input  wire logic [5:0]           AVS_ADDRESS_I,
   input  wire logic                 AVS_READ_I,
   input  wire logic                 AVS_WRITE_I,
   input  wire logic [31:0]          AVS_WRITEDATA_I,
   input  wire logic [3:0]           AVS_BYTEENABLE_I,
   output      logic [31:0]          AVS_READDATA_O,
   output      logic                 AVS_WAITREQUEST_O,
   input  wire logic                 SRC_I,
   input  wire logic                 GATE_I,
   input  wire logic                 AUX_I,
   input  wire logic                 ENC_A_I,
   input  wire logic                 ENC_B_I,
   input  wire logic                 ENC_Z_I,
   output      logic                 PULSE_O,
   output      ecpg_pkg::ecpg_stream_t DMA_STREAM_O,
   input  wire logic                 DMA_READY_I
);
   import ecpg_pkg::*;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!NRST_I);

   logic [`ECPG_PIN_N-1:0] pin_raw;
   logic [`ECPG_PIN_N-1:0] meta_q;
   logic [`ECPG_PIN_N-1:0] sync_q;
   logic [`ECPG_PIN_N-1:0] prev_q;
   logic [`ECPG_PIN_N-1:0] rise;
   logic [`ECPG_PIN_N-1:0] fall;

   ecpg_cfg_t   cfg_q;
   ecpg_state_t st_q;
   ecpg_state_t st_d;
   logic [31:0] reload_q;
   logic [31:0] delay_q;
   logic [31:0] high_q;
   logic [31:0] low_q;
   logic [31:0] count_q;
   logic [31:0] count_d;
   logic [31:0] save_q;
   logic [31:0] save_d;
   logic        save_ev;
   logic        armed_q;
   logic        out_q;
   logic        dma_pend_q;
   logic        overrun_q;
   logic        started_q;
   logic        ack_q;
   logic [31:0] rdata_q;

   // two-stage synchronisers; prev_q only ever looks at the second stage
   assign pin_raw = {ENC_Z_I, ENC_B_I, ENC_A_I, AUX_I, GATE_I, SRC_I};
   generate
      for (genvar i = 0; i < `ECPG_PIN_N; i++) begin : g_sync
         always_ff @(posedge MCLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
               prev_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= pin_raw[i];
               sync_q[i] <= meta_q[i];
               prev_q[i] <= sync_q[i];
            end
         end
         assign rise[i] = sync_q[i] & ~prev_q[i];
         assign fall[i] = ~sync_q[i] & prev_q[i];
      end
   endgenerate

   // bus decode: one wait cycle, then the answer
   logic        bus_req;
   logic        wr_go;
   logic [31:0] wmask;
   logic        sel_ctrl;
   logic        sel_cmd;
   logic        sel_reload;
   logic        sel_delay;
   logic        sel_high;
   logic        sel_low;
   logic        sel_count;
   logic        sel_save;
   logic        sel_status;
   logic        cmd_arm;
   logic        cmd_disarm;
   logic [31:0] status;
   logic [31:0] rd_mux;
   logic [31:0] ctrl_merged;

   assign bus_req           = AVS_READ_I | AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = bus_req & ~ack_q;
   assign wr_go             = AVS_WRITE_I & ack_q;
   assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                   {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
   assign sel_ctrl   = AVS_ADDRESS_I == `ECPG_OFS_CTRL;
   assign sel_cmd    = AVS_ADDRESS_I == `ECPG_OFS_CMD;
   assign sel_reload = AVS_ADDRESS_I == `ECPG_OFS_RELOAD;
   assign sel_delay  = AVS_ADDRESS_I == `ECPG_OFS_DELAY;
   assign sel_high   = AVS_ADDRESS_I == `ECPG_OFS_HIGH;
   assign sel_low    = AVS_ADDRESS_I == `ECPG_OFS_LOW;
   assign sel_count  = AVS_ADDRESS_I == `ECPG_OFS_COUNT;
   assign sel_save   = AVS_ADDRESS_I == `ECPG_OFS_SAVE;
   assign sel_status = AVS_ADDRESS_I == `ECPG_OFS_STATUS;
   assign cmd_arm    = wr_go & sel_cmd & AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[`ECPG_CMD_ARM];
   assign cmd_disarm = wr_go & sel_cmd & AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[`ECPG_CMD_DISARM];
   assign ctrl_merged = ({21'h000000, cfg_q} & ~wmask) | (AVS_WRITEDATA_I & wmask);

   // status word: state, overrun, output level, dma pending, armed
   assign status = {25'h0000000, st_q, overrun_q, out_q, dma_pend_q, armed_q};
   assign rd_mux = sel_ctrl   ? {21'h000000, cfg_q} :
                   sel_reload ? reload_q :
                   sel_delay  ? delay_q  :
                   sel_high   ? high_q   :
                   sel_low    ? low_q    :
                   sel_count  ? count_q  :
                   sel_save   ? save_q   :
                   sel_status ? status   : `ECPG_WORD_RST;

   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ack_q   <= 1'b0;
         rdata_q <= `ECPG_WORD_RST;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (AVS_READ_I && !ack_q)
            rdata_q <= rd_mux;
      end
   end
   assign AVS_READDATA_O = rdata_q;

   // configuration storage, byte-lane writes
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         cfg_q    <= `ECPG_CTRL_RST;
         reload_q <= `ECPG_WORD_RST;
         delay_q  <= `ECPG_WORD_RST;
         high_q   <= `ECPG_WIDTH_RST;
         low_q    <= `ECPG_WIDTH_RST;
      end else if (wr_go) begin
         if (sel_ctrl)   cfg_q    <= ctrl_merged[`ECPG_CTRL_W-1:0];
         if (sel_reload) reload_q <= (reload_q & ~wmask) | (AVS_WRITEDATA_I & wmask);
         if (sel_delay)  delay_q  <= (delay_q & ~wmask) | (AVS_WRITEDATA_I & wmask);
         if (sel_high)   high_q   <= (high_q & ~wmask) | (AVS_WRITEDATA_I & wmask);
         if (sel_low)    low_q    <= (low_q & ~wmask) | (AVS_WRITEDATA_I & wmask);
      end
   end

   // edge and mode decode
   logic        src_edge;
   logic        gate_edge;
   logic        aux_edge;
   logic        gate_active;
   logic        enc_a;
   logic        enc_b;
   logic        q_step;
   logic        q_up;
   logic        reload_hit;
   logic        is_quad;
   logic        is_two;
   logic        is_sep;
   logic        is_pulse;
   logic        needs_trig;
   logic        paused;
   logic        tick;
   logic        start_ev;
   logic [31:0] count_inc;
   logic [31:0] count_dec;
   logic        dly_done;
   logic        hi_done;
   logic        lo_done;

   assign src_edge    = cfg_q.src_fall  ? fall[`ECPG_PIN_SRC]  : rise[`ECPG_PIN_SRC];
   assign gate_edge   = cfg_q.gate_fall ? fall[`ECPG_PIN_GATE] : rise[`ECPG_PIN_GATE];
   assign aux_edge    = cfg_q.aux_fall  ? fall[`ECPG_PIN_AUX]  : rise[`ECPG_PIN_AUX];
   assign gate_active = sync_q[`ECPG_PIN_GATE] ^ cfg_q.pause_low;
   assign enc_a       = sync_q[`ECPG_PIN_A];
   assign enc_b       = sync_q[`ECPG_PIN_B];
   // one channel moved; direction from new A against old B
   assign q_step     = rise[`ECPG_PIN_A] ^ fall[`ECPG_PIN_A] ^ rise[`ECPG_PIN_B] ^ fall[`ECPG_PIN_B];
   assign q_up       = enc_a ^ prev_q[`ECPG_PIN_B];
   // index is sampled as a level, so a short index pulse inside the phase is enough
   assign reload_hit = ({enc_a, enc_b} == cfg_q.phase) & sync_q[`ECPG_PIN_Z];
   assign is_quad    = cfg_q.mode == ECPG_ENC_QUAD;
   assign is_two     = cfg_q.mode == ECPG_ENC_TWO;
   assign is_sep     = (cfg_q.mode == ECPG_SEP_SINGLE) | (cfg_q.mode == ECPG_SEP_BUF);
   assign is_pulse   = cfg_q.mode[2];
   assign needs_trig = (cfg_q.mode == ECPG_PUL_TRIG) | (cfg_q.mode == ECPG_PUL_RETRIG) |
                       ((cfg_q.mode == ECPG_PUL_TRAIN) & cfg_q.trig_en);
   assign paused     = (cfg_q.mode == ECPG_PUL_TRAIN) & ~cfg_q.trig_en & cfg_q.pause_en &
                       gate_active;
   assign tick       = src_edge & ~paused;
   assign start_ev   = is_pulse ? gate_edge :
                       ((cfg_q.mode == ECPG_SEP_BUF) & started_q) ? gate_edge : aux_edge;
   assign count_inc  = count_q + `ECPG_ONE;
   assign count_dec  = count_q - `ECPG_ONE;
   // zero widths behave as one edge
   assign dly_done   = count_q >= delay_q;
   assign hi_done    = count_inc >= high_q;
   assign lo_done    = count_inc >= low_q;

   // main sequencer; an arm or disarm command overrides everything
   always_comb begin
      st_d    = st_q;
      count_d = count_q;
      save_d  = save_q;
      save_ev = 1'b0;
      if (cmd_disarm) begin
         st_d = ECPG_ST_IDLE;
      end else if (cmd_arm) begin
         count_d = `ECPG_WORD_RST;
         if (is_pulse)
            st_d = needs_trig ? ECPG_ST_WAIT : ECPG_ST_DELAY;
         else
            st_d = is_sep ? ECPG_ST_WAIT : ECPG_ST_RUN;
      end else begin
         unique case (st_q)
            ECPG_ST_IDLE, ECPG_ST_DONE: begin
               st_d = st_q;
            end
            ECPG_ST_WAIT: begin
               if (start_ev) begin
                  count_d = `ECPG_WORD_RST;
                  st_d    = is_pulse ? ECPG_ST_DELAY : ECPG_ST_RUN;
               end
            end
            ECPG_ST_RUN: begin
               if (is_quad) begin
                  // a step wins; the reload follows on the next cycle
                  if (q_step)
                     count_d = q_up ? count_inc : count_dec;
                  else if (reload_hit)
                     count_d = reload_q;
               end else if (is_two) begin
                  if (rise[`ECPG_PIN_A] && !rise[`ECPG_PIN_B])
                     count_d = count_inc;
                  else if (rise[`ECPG_PIN_B] && !rise[`ECPG_PIN_A])
                     count_d = count_dec;
               end else if (gate_edge) begin
                  save_d  = count_q;
                  save_ev = 1'b1;
                  st_d    = (cfg_q.mode == ECPG_SEP_BUF) ? ECPG_ST_WAIT : ECPG_ST_DONE;
               end else if (src_edge) begin
                  count_d = count_inc;
               end
            end
            ECPG_ST_DELAY: begin
               if (dly_done) begin
                  count_d = `ECPG_WORD_RST;
                  st_d    = ECPG_ST_HIGH;
               end else if (tick) begin
                  count_d = count_inc;
               end
            end
            ECPG_ST_HIGH: begin
               if (tick && hi_done) begin
                  count_d = `ECPG_WORD_RST;
                  if (cfg_q.mode == ECPG_PUL_TRAIN)
                     st_d = ECPG_ST_LOW;
                  else if (cfg_q.mode == ECPG_PUL_RETRIG)
                     st_d = ECPG_ST_WAIT;
                  else
                     st_d = ECPG_ST_DONE;
               end else if (tick) begin
                  count_d = count_inc;
               end
            end
            ECPG_ST_LOW: begin
               if (tick && lo_done) begin
                  count_d = `ECPG_WORD_RST;
                  st_d    = ECPG_ST_HIGH;
               end else if (tick) begin
                  count_d = count_inc;
               end
            end
            default: begin
               st_d = ECPG_ST_IDLE;
            end
         endcase
      end
   end

   // state, 32-bit count and save register
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         st_q    <= ECPG_ST_IDLE;
         count_q <= `ECPG_WORD_RST;
         save_q  <= `ECPG_WORD_RST;
         out_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         count_q <= count_d;
         save_q  <= save_d;
         out_q   <= st_d == ECPG_ST_HIGH;
      end
   end

   // arm flag and buffered restart flag
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         armed_q   <= 1'b0;
         started_q <= 1'b0;
      end else if (cmd_disarm || cmd_arm) begin
         armed_q   <= cmd_arm & ~cmd_disarm;
         started_q <= 1'b0;
      end else if (save_ev) begin
         started_q <= 1'b1;
      end
   end

   // dma offer: new save wins over a same-cycle take; overrun if one is lost
   always_ff @(posedge MCLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         dma_pend_q <= 1'b0;
         overrun_q  <= 1'b0;
      end else begin
         if (save_ev && cfg_q.mode == ECPG_SEP_BUF)
            dma_pend_q <= 1'b1;
         else if (DMA_READY_I)
            dma_pend_q <= 1'b0;
         if (save_ev && dma_pend_q && !DMA_READY_I)
            overrun_q <= 1'b1;
         else if (cmd_arm)
            overrun_q <= 1'b0;
      end
   end

   assign PULSE_O      = out_q;
   assign DMA_STREAM_O = '{valid: dma_pend_q, data: save_q};

   a_quad_up_step: assert property (
      (st_q == ECPG_ST_RUN && is_quad && q_step && q_up && !cmd_arm && !cmd_disarm)
      |=> count_q == $past(count_q) + `ECPG_ONE)
      else $error("quad step up did not add one");

   a_quad_down_dir: assert property (
      (st_q == ECPG_ST_RUN && is_quad && q_step && !q_up && !cmd_arm && !cmd_disarm)
      |=> count_q == $past(count_q) - `ECPG_ONE)
      else $error("quad step down did not subtract one");

   a_index_reload: assert property (
      (st_q == ECPG_ST_RUN && is_quad && reload_hit && !q_step && !cmd_arm && !cmd_disarm)
      |=> count_q == $past(reload_q))
      else $error("index reload missed");

   a_step_before_reload: assert property (
      (st_q == ECPG_ST_RUN && is_quad && reload_hit && q_step && !cmd_arm && !cmd_disarm)
      |=> (count_q == $past(count_q) + `ECPG_ONE || count_q == $past(count_q) - `ECPG_ONE))
      else $error("reload took priority over a step");

   a_two_pulse_up: assert property (
      (st_q == ECPG_ST_RUN && is_two && rise[`ECPG_PIN_A] && !rise[`ECPG_PIN_B] &&
       !cmd_arm && !cmd_disarm)
      |=> count_q == $past(count_q) + `ECPG_ONE)
      else $error("two-pulse up count wrong");

   a_idle_no_count: assert property (
      (st_q == ECPG_ST_IDLE && !cmd_arm) |=> $stable(count_q) && st_q == ECPG_ST_IDLE)
      else $error("counted while not armed");

   a_sep_save_count: assert property (
      (st_q == ECPG_ST_RUN && is_sep && gate_edge && !cmd_arm && !cmd_disarm)
      |=> save_q == $past(count_q) && st_q != ECPG_ST_RUN)
      else $error("gate edge did not save and stop");

   a_single_hold_save: assert property (
      (st_q == ECPG_ST_DONE && !cmd_arm && !cmd_disarm)
      |=> st_q == ECPG_ST_DONE && $stable(save_q))
      else $error("held result disturbed");

   a_retrig_gate_ignored: assert property (
      (st_q == ECPG_ST_HIGH && cfg_q.mode == ECPG_PUL_RETRIG && gate_edge && !tick &&
       !cmd_arm && !cmd_disarm)
      |=> st_q == ECPG_ST_HIGH && PULSE_O)
      else $error("gate disturbed pulse in progress");

   a_pause_freezes_train: assert property (
      (paused && (st_q == ECPG_ST_HIGH || st_q == ECPG_ST_LOW) && !cmd_arm && !cmd_disarm)
      |=> $stable(count_q) && $stable(st_q) && $stable(PULSE_O))
      else $error("train moved while paused");

   a_dma_offer_save: assert property (
      (save_ev && cfg_q.mode == ECPG_SEP_BUF)
      |=> DMA_STREAM_O.valid && DMA_STREAM_O.data == $past(count_q))
      else $error("saved count not offered to dma");

endmodule

// ### sim/ecpg_far.sv
`timescale 1ns/1ps
`include "ecpg_regs.svh"

// encoder, trigger and source lines as seen from outside the counter
module ecpg_far (
   input  wire logic       clk_i,
   output      logic [5:0] pins_o
);
   // quadrature phases {a,b} in forward order 00,10,11,01
   localparam logic [7:0] seq = 8'h78;
   int q = 0;

   initial pins_o = 6'h00;

   // each level is held six clocks so the sync flops never lose it
   task automatic set(input int i, input logic v);
      @(posedge clk_i);
      pins_o[i] <= v;
      repeat (5) @(posedge clk_i);
   endtask

   task automatic pulse(input int i, input int n);
      repeat (n) begin
         set(i, 1'b1);
         set(i, 1'b0);
      end
   endtask

   // one line changes per step, a leads b going up
   task automatic quad(input int n, input logic up);
      repeat (n) begin
         q = up ? (q + 1) % 4 : (q + 3) % 4;
         @(posedge clk_i);
         pins_o[`ECPG_PIN_A] <= seq[2 * q + 1];
         pins_o[`ECPG_PIN_B] <= seq[2 * q];
         repeat (5) @(posedge clk_i);
      end
   endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
`include "ecpg_regs.svh"

module tb;
   import ecpg_pkg::*;
   logic         clk = 1'b0;
   logic         rst_n = 1'b0;
   logic [5:0]   adr = 6'h00;
   logic         rd_en = 1'b0;
   logic         wr_en = 1'b0;
   logic [31:0]  wdat = 32'h00000000;
   logic         dma_rdy = 1'b0;
   logic [31:0]  rdat;
   logic         wait_req;
   logic         pulse;
   logic [5:0]   pins;
   ecpg_stream_t dma;
   int           err_total = 0;
   int           checked = 0;
   int           cyc = 0;

   ecpg_counter ecpg_counter_i (.MCLK_I(clk), .NRST_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd_en),
      .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wait_req), .SRC_I(pins[`ECPG_PIN_SRC]), .GATE_I(pins[`ECPG_PIN_GATE]),
      .AUX_I(pins[`ECPG_PIN_AUX]), .ENC_A_I(pins[`ECPG_PIN_A]), .ENC_B_I(pins[`ECPG_PIN_B]),
      .ENC_Z_I(pins[`ECPG_PIN_Z]), .PULSE_O(pulse), .DMA_STREAM_O(dma), .DMA_READY_I(dma_rdy));
   ecpg_far ecpg_far_i (.clk_i(clk), .pins_o(pins));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // a hung wait ends the run as a failure
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // request held until waitrequest is sampled low, then released
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr_en <= w;
      rd_en <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_req !== 1'b0 && n < 50);
      r = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      if (n >= 50) chk("bus answer", 32'h0, 32'h1);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input string nm);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, r, exp);
   endtask

   task automatic start(input logic [31:0] ctrl);
      wr(`ECPG_OFS_CTRL, ctrl);
      wr(`ECPG_OFS_CMD, 32'h1);
   endtask

   // the word is held until ready has been seen with it
   task automatic dma_take(input logic [31:0] exp);
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (dma.valid !== 1'b1 && n < 50);
      chk("dma data", dma.data, exp);
      dma_rdy <= 1'b1;
      @(posedge clk);
      dma_rdy <= 1'b0;
      @(posedge clk);
      chk("dma valid", {31'h0, dma.valid}, 32'h0);
   endtask

   task automatic t_regs();
      rdc(`ECPG_OFS_CTRL, 32'h0, "ctrl");
      rdc(`ECPG_OFS_HIGH, 32'h1, "high");
      wr(`ECPG_OFS_DELAY, 32'hA5A50F0F);
      rdc(`ECPG_OFS_DELAY, 32'hA5A50F0F, "delay");
      rdc(6'h24, 32'h0, "unmapped");
      wr(`ECPG_OFS_COUNT, 32'hFFFFFFFF);
      rdc(`ECPG_OFS_COUNT, 32'h0, "count ro");
   endtask

   task automatic t_quad();
      start(32'h0);
      ecpg_far_i.quad(8, 1'b1);
      rdc(`ECPG_OFS_COUNT, 32'h8, "quad up");
      ecpg_far_i.quad(3, 1'b0);
      rdc(`ECPG_OFS_COUNT, 32'h5, "quad down");
      wr(`ECPG_OFS_CMD, 32'h2);
      ecpg_far_i.quad(2, 1'b1);
      rdc(`ECPG_OFS_COUNT, 32'h5, "disarmed");
   endtask

   // reload phase a=1 b=1, index raised one phase early
   task automatic t_index();
      wr(`ECPG_OFS_RELOAD, 32'h64);
      start(32'hC0);
      ecpg_far_i.set(`ECPG_PIN_Z, 1'b1);
      rdc(`ECPG_OFS_COUNT, 32'h0, "no reload");
      ecpg_far_i.quad(1, 1'b0);
      rdc(`ECPG_OFS_COUNT, 32'h64, "reload");
      ecpg_far_i.set(`ECPG_PIN_Z, 1'b0);
      ecpg_far_i.quad(1, 1'b1);
      rdc(`ECPG_OFS_COUNT, 32'h65, "after reload");
      ecpg_far_i.quad(1, 1'b1);
   endtask

   task automatic t_two();
      start(32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_B, 1);
      rdc(`ECPG_OFS_COUNT, 32'hFFFFFFFF, "wrap");
      ecpg_far_i.pulse(`ECPG_PIN_A, 3);
      rdc(`ECPG_OFS_COUNT, 32'h2, "two pulse");
   endtask

   task automatic t_sep();
      start(32'h2);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      ecpg_far_i.pulse(`ECPG_PIN_AUX, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 5);
      ecpg_far_i.pulse(`ECPG_PIN_AUX, 1);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      rdc(`ECPG_OFS_SAVE, 32'h5, "sep save");
      ecpg_far_i.pulse(`ECPG_PIN_AUX, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      rdc(`ECPG_OFS_SAVE, 32'h5, "sep held");
   endtask

   // falling gate is active, so the rising gate edge must not stop
   task automatic t_buf();
      start(32'h13);
      ecpg_far_i.pulse(`ECPG_PIN_AUX, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 3);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b0);
      dma_take(32'h4);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b0);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      dma_take(32'h2);
   endtask

   // falling source edges, delay 2, width 3
   task automatic t_pulse();
      wr(`ECPG_OFS_DELAY, 32'h2);
      wr(`ECPG_OFS_HIGH, 32'h3);
      start(32'h0C);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("delay", {31'h0, pulse}, 32'h0);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("pulse on", {31'h0, pulse}, 32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      chk("width", {31'h0, pulse}, 32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("pulse off", {31'h0, pulse}, 32'h0);
   endtask

   // high 2, low 3, gate high pauses
   task automatic t_train();
      wr(`ECPG_OFS_DELAY, 32'h0);
      wr(`ECPG_OFS_HIGH, 32'h2);
      wr(`ECPG_OFS_LOW, 32'h3);
      start(32'h207);
      repeat (4) @(posedge clk);
      chk("train start", {31'h0, pulse}, 32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      chk("train low", {31'h0, pulse}, 32'h0);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 3);
      chk("paused", {31'h0, pulse}, 32'h0);
      ecpg_far_i.set(`ECPG_PIN_GATE, 1'b0);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      chk("resumed", {31'h0, pulse}, 32'h0);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("train high", {31'h0, pulse}, 32'h1);
   endtask

   // triggered then retriggerable single pulse, delay 1, width 2
   task automatic t_trig();
      wr(`ECPG_OFS_DELAY, 32'h1);
      wr(`ECPG_OFS_HIGH, 32'h2);
      start(32'h05);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      chk("trig wait", {31'h0, pulse}, 32'h0);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("trig pulse", {31'h0, pulse}, 32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 2);
      rdc(`ECPG_OFS_STATUS, 32'h61, "trig once");
      // a gate edge inside the pulse must neither cut nor restart it
      start(32'h06);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      chk("retrig busy", {31'h0, pulse}, 32'h1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 4);
      chk("retrig wait", {31'h0, pulse}, 32'h0);
      ecpg_far_i.pulse(`ECPG_PIN_GATE, 1);
      ecpg_far_i.pulse(`ECPG_PIN_SRC, 1);
      chk("retrig again", {31'h0, pulse}, 32'h1);
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_quad();
      t_index();
      t_two();
      t_sep();
      t_buf();
      t_pulse();
      t_train();
      t_trig();
      finish_test();
   end
endmodule
